// ---- design/fcb_pkg.sv ----
package fcb_pkg;
	// instruction field layout
	localparam int PC_WIDTH = 21;
	localparam int OPC_HI_MSB = 15;
	localparam int OPC_HI_LSB = 8;
	localparam int OFS_MSB = 7;
	localparam int OFS_LSB = 0;
	// opcode high bytes
	localparam logic [7:0] OPC_BRANCH_ON_NEGATIVE = 8'he6;
	localparam logic [7:0] OPC_BRANCH_ON_CARRY_CLEAR = 8'he3;
	localparam logic [7:0] OPC_BRANCH_ON_NOT_NEGATIVE = 8'he7;
	// phases per instruction cycle
	localparam int PHASES = 4;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_Q4 = 2'h3;
	// reset values
	localparam logic [PC_WIDTH-1:0] PC_RESET = 21'h000000;
	localparam logic [1:0] PHASE_RESET = 2'h0;
	// status flag positions in the flag word
	localparam int FLAG_CARRY = 0;
	localparam int FLAG_NEGATIVE = 4;
	typedef enum logic [1:0] {
		FCB_NONE,
		FCB_NEG,
		FCB_CARRY_CLR,
		FCB_NOT_NEG
	} fcb_kind_e;
endpackage : fcb_pkg

// ---- design/fcb_phase_gen.sv ----
module fcb_phase_gen (
	input wire logic clock,
	input wire logic reset,
	output logic [1:0] phase,
	output logic cycle_start,
	output logic cycle_end
);
	logic [1:0] phase_ff;
	logic [1:0] nxt_phase;

	// four-phase counter, one clock per phase
	always_comb begin
		nxt_phase = phase_ff + 2'h1;
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			phase_ff <= fcb_pkg::PHASE_RESET;
		end else begin
			phase_ff <= nxt_phase;
		end
	end

	assign phase = phase_ff;
	assign cycle_start = (phase_ff == fcb_pkg::PH_Q1);
	assign cycle_end = (phase_ff == fcb_pkg::PH_Q4);
endmodule : fcb_phase_gen

// ---- design/fcb_flag_conditional_branch_unit.sv ----
////////////////////////////////////////////////////////////////////////////////
module fcb_flag_conditional_branch_unit #(
	parameter int PC_W = fcb_pkg::PC_WIDTH
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [15:0] instr,
	input wire logic instr_valid,
	input wire logic [7:0] status_flags,
	output logic [PC_W-1:0] pc,
	output logic pc_load,
	output logic is_branch,
	output logic branch_taken,
	output logic flush,
	output logic busy,
	output logic [1:0] q_phase,
	output logic flags_write
);
	typedef enum logic [1:0] {
		FCB_IDLE,
		FCB_EXEC,
		FCB_NOP
	} fcb_state_e;

	logic [1:0] phase;
	logic cycle_start;
	logic cycle_end;

	fcb_phase_gen u_phase (
		.clock(clock),
		.reset(reset),
		.phase(phase),
		.cycle_start(cycle_start),
		.cycle_end(cycle_end)
	);

	fcb_state_e state_ff, nxt_state;
	fcb_pkg::fcb_kind_e kind_ff, nxt_kind;
	logic [7:0] ofs_ff, nxt_ofs;
	logic [PC_W-1:0] pc_ff, nxt_pc;
	logic pc_load_ff, nxt_pc_load;
	logic is_branch_ff, nxt_is_branch;
	logic taken_ff, nxt_taken;
	logic flush_ff, nxt_flush;
	logic busy_ff, nxt_busy;
	logic [1:0] q_phase_ff, nxt_q_phase;
	fcb_pkg::fcb_kind_e dec_kind;
	logic cond_true;
	logic [PC_W-1:0] target;

	////////////////////////////////////////////////////////////////////////////
	// opcode decode on the high byte
	always_comb begin
		unique case (instr[fcb_pkg::OPC_HI_MSB:fcb_pkg::OPC_HI_LSB])
			fcb_pkg::OPC_BRANCH_ON_NEGATIVE: dec_kind = fcb_pkg::FCB_NEG;
			fcb_pkg::OPC_BRANCH_ON_CARRY_CLEAR: dec_kind = fcb_pkg::FCB_CARRY_CLR;
			fcb_pkg::OPC_BRANCH_ON_NOT_NEGATIVE: dec_kind = fcb_pkg::FCB_NOT_NEG;
			default: dec_kind = fcb_pkg::FCB_NONE;
		endcase
	end

	// flags sampled live in q3 so a flag set by the prior instruction counts
	always_comb begin
		unique case (kind_ff)
			fcb_pkg::FCB_NEG: cond_true = status_flags[fcb_pkg::FLAG_NEGATIVE];
			fcb_pkg::FCB_CARRY_CLR: cond_true = ~status_flags[fcb_pkg::FLAG_CARRY];
			fcb_pkg::FCB_NOT_NEG: cond_true = ~status_flags[fcb_pkg::FLAG_NEGATIVE];
			default: cond_true = 1'b0;
		endcase
	end

	// pc_ff already holds branch address + 2; sign-extended offset shifted left once
	always_comb begin
		target = pc_ff + PC_W'({{(PC_W-9){ofs_ff[7]}}, ofs_ff, 1'b0});
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencer and pc next values
	always_comb begin
		nxt_state = state_ff;
		nxt_kind = kind_ff;
		nxt_ofs = ofs_ff;
		nxt_pc = pc_ff;
		nxt_pc_load = 1'b0;
		nxt_is_branch = is_branch_ff;
		nxt_taken = taken_ff;
		nxt_flush = flush_ff;
		nxt_busy = busy_ff;
		nxt_q_phase = phase + 2'h1;
		unique case (state_ff)
			FCB_IDLE: begin
				if (cycle_start && instr_valid) begin
					nxt_kind = dec_kind;
					nxt_ofs = instr[fcb_pkg::OFS_MSB:fcb_pkg::OFS_LSB];
					nxt_pc = pc_ff + PC_W'(2);
					nxt_is_branch = (dec_kind != fcb_pkg::FCB_NONE);
					nxt_taken = 1'b0;
					nxt_flush = 1'b0;
					nxt_busy = 1'b1;
					nxt_state = FCB_EXEC;
				end
			end
			FCB_EXEC: begin
				// decision in q3 so the pc write lands in q4
				if (phase == fcb_pkg::PH_Q4 - 2'h1) begin
					if (cond_true) begin
						nxt_pc = target;
						nxt_pc_load = 1'b1;
						nxt_taken = 1'b1;
					end
				end
				if (cycle_end) begin
					if (taken_ff) begin
						nxt_flush = 1'b1;
						nxt_state = FCB_NOP;
					end else begin
						nxt_busy = 1'b0;
						nxt_is_branch = 1'b0;
						nxt_state = FCB_IDLE;
					end
				end
			end
			FCB_NOP: begin
				// prefetched word is discarded for the whole cycle
				if (cycle_end) begin
					nxt_flush = 1'b0;
					nxt_busy = 1'b0;
					nxt_taken = 1'b0;
					nxt_is_branch = 1'b0;
					nxt_state = FCB_IDLE;
				end
			end
			default: nxt_state = FCB_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_ff <= FCB_IDLE;
			kind_ff <= fcb_pkg::FCB_NONE;
			ofs_ff <= 8'h00;
			pc_ff <= fcb_pkg::PC_RESET;
			pc_load_ff <= 1'b0;
			is_branch_ff <= 1'b0;
			taken_ff <= 1'b0;
			flush_ff <= 1'b0;
			busy_ff <= 1'b0;
			q_phase_ff <= fcb_pkg::PHASE_RESET;
		end else begin
			state_ff <= nxt_state;
			kind_ff <= nxt_kind;
			ofs_ff <= nxt_ofs;
			pc_ff <= nxt_pc;
			pc_load_ff <= nxt_pc_load;
			is_branch_ff <= nxt_is_branch;
			taken_ff <= nxt_taken;
			flush_ff <= nxt_flush;
			busy_ff <= nxt_busy;
			q_phase_ff <= nxt_q_phase;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs straight from flops; flag write port held inactive
	assign pc = pc_ff;
	assign pc_load = pc_load_ff;
	assign is_branch = is_branch_ff;
	assign branch_taken = taken_ff;
	assign flush = flush_ff;
	assign busy = busy_ff;
	assign q_phase = q_phase_ff;
	assign flags_write = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// checks
	a_pc_plus_two: assert property (@(posedge clock) disable iff (reset)
		(state_ff == FCB_IDLE && cycle_start && instr_valid) |=> (pc_ff == $past(pc_ff) + PC_W'(2)))
		else $error("pc not advanced by two on fetch");
	a_target_calc: assert property (@(posedge clock) disable iff (reset)
		pc_load_ff |-> (pc_ff == $past(pc_ff) + PC_W'({{(PC_W-9){ofs_ff[7]}}, ofs_ff, 1'b0})))
		else $error("branch target wrong");
	a_load_in_q4: assert property (@(posedge clock) disable iff (reset)
		pc_load_ff |-> (phase == fcb_pkg::PH_Q4))
		else $error("pc written outside last phase");
	a_neg_taken: assert property (@(posedge clock) disable iff (reset)
		(state_ff == FCB_EXEC && phase == 2'h2 && kind_ff == fcb_pkg::FCB_NEG)
		|=> (pc_load_ff == $past(status_flags[fcb_pkg::FLAG_NEGATIVE])))
		else $error("negative branch decision wrong");
	a_cc_taken: assert property (@(posedge clock) disable iff (reset)
		(state_ff == FCB_EXEC && phase == 2'h2 && kind_ff == fcb_pkg::FCB_CARRY_CLR)
		|=> (pc_load_ff == !$past(status_flags[fcb_pkg::FLAG_CARRY])))
		else $error("carry clear branch decision wrong");
	a_nn_taken: assert property (@(posedge clock) disable iff (reset)
		(state_ff == FCB_EXEC && phase == 2'h2 && kind_ff == fcb_pkg::FCB_NOT_NEG)
		|=> (pc_load_ff == !$past(status_flags[fcb_pkg::FLAG_NEGATIVE])))
		else $error("not negative branch decision wrong");
	a_taken_two: assert property (@(posedge clock) disable iff (reset)
		$rose(pc_load_ff) |=> busy_ff[*4] ##1 !busy_ff)
		else $error("taken branch not two cycles");
	a_nop_flush: assert property (@(posedge clock) disable iff (reset)
		$rose(pc_load_ff) |=> flush_ff[*4] ##1 !flush_ff)
		else $error("second cycle not flushed");
	a_no_kind_no_load: assert property (@(posedge clock) disable iff (reset)
		(kind_ff == fcb_pkg::FCB_NONE) |-> !nxt_pc_load)
		else $error("non-branch loaded pc");
	a_no_flag_write: assert property (@(posedge clock) disable iff (reset)
		!flags_write)
		else $error("flags written");
endmodule : fcb_flag_conditional_branch_unit

// ---- tb/tb_top.sv ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock;
	logic reset;
	logic [15:0] instr;
	logic instr_valid;
	logic [7:0] status_flags;
	logic [20:0] pc;
	logic pc_load;
	logic is_branch;
	logic branch_taken;
	logic flush;
	logic busy;
	logic [1:0] q_phase;
	logic flags_write;
	int miscompares = 0;
	int cmp_count = 0;
	// reference program counter, advanced by the rules alone
	logic [20:0] model_pc;

	fcb_flag_conditional_branch_unit uut (
		.clock(clock),
		.reset(reset),
		.instr(instr),
		.instr_valid(instr_valid),
		.status_flags(status_flags),
		.pc(pc),
		.pc_load(pc_load),
		.is_branch(is_branch),
		.branch_taken(branch_taken),
		.flush(flush),
		.busy(busy),
		.q_phase(q_phase),
		.flags_write(flags_write)
	);

	////////////////////////////////////////////////////////////////////////////////
	// 10 mhz clock, one clock per phase
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one instruction from the idle state; flags held steady so the live sample is well defined
	task automatic run(input logic [7:0] op, input logic [7:0] ofs, input logic [7:0] flg, input logic tk,
		input logic br);
		logic [20:0] exp;
		int n;
		int wt;
		int loads;
		int fl;
		int la;
		logic br_seen;
		logic fw;
		int tkc;
		logic [1:0] qp;
		exp = model_pc + 21'h2 + (tk ? {{12{ofs[7]}}, ofs, 1'b0} : 21'h0);
		status_flags = flg;
		instr = {op, ofs};
		instr_valid = 1'b1;
		wt = 0;
		while (busy !== 1'b1 && wt < 8) begin
			@(negedge clock);
			wt++;
		end
		// drop valid at once, or the unit would take the same word again when idle
		instr_valid = 1'b0;
		n = 0;
		loads = 0;
		fl = 0;
		la = 0;
		br_seen = 1'b0;
		fw = 1'b0;
		tkc = 0;
		qp = 2'h0;
		while (busy === 1'b1 && n < 16) begin
			n++;
			if (pc_load === 1'b1) begin
				loads++;
				la = n;
				qp = q_phase;
			end
			if (flush === 1'b1) fl++;
			if (branch_taken === 1'b1) tkc++;
			br_seen = br_seen | is_branch;
			fw = fw | flags_write;
			@(negedge clock);
		end
		// busy rises after the take edge and drops on the last edge, so q1 of the next cycle is already idle
		chk(pc, exp);
		chk(n, tk ? 7 : 3);
		chk(loads, tk);
		chk(la, tk ? 3 : 0);
		chk(qp, tk ? fcb_pkg::PH_Q4 : 2'h0);
		chk(fl, tk ? 4 : 0);
		chk(tkc, tk ? 5 : 0);
		chk(br_seen, br);
		chk(fw, 0);
		model_pc = exp;
	endtask : run

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_negative;
		run(fcb_pkg::OPC_BRANCH_ON_NEGATIVE, 8'h05, 8'h10, 1'b1, 1'b1);
		run(fcb_pkg::OPC_BRANCH_ON_NEGATIVE, 8'h05, 8'hef, 1'b0, 1'b1);
		$display("test negative done");
	endtask : t_negative

	task automatic t_carry_clear;
		run(fcb_pkg::OPC_BRANCH_ON_CARRY_CLEAR, 8'hfe, 8'h10, 1'b1, 1'b1);
		run(fcb_pkg::OPC_BRANCH_ON_CARRY_CLEAR, 8'hfe, 8'h01, 1'b0, 1'b1);
		$display("test carry clear done");
	endtask : t_carry_clear

	task automatic t_not_negative;
		run(fcb_pkg::OPC_BRANCH_ON_NOT_NEGATIVE, 8'h7f, 8'hef, 1'b1, 1'b1);
		run(fcb_pkg::OPC_BRANCH_ON_NOT_NEGATIVE, 8'h7f, 8'h10, 1'b0, 1'b1);
		$display("test not negative done");
	endtask : t_not_negative

	// most negative and zero offsets, back to back with the previous branch
	task automatic t_bounds;
		run(fcb_pkg::OPC_BRANCH_ON_NEGATIVE, 8'h80, 8'hff, 1'b1, 1'b1);
		run(fcb_pkg::OPC_BRANCH_ON_CARRY_CLEAR, 8'h00, 8'h00, 1'b1, 1'b1);
		$display("test offset bounds done");
	endtask : t_bounds

	// neighbouring opcode outside the set only advances pc
	task automatic t_other;
		run(8'he2, 8'h05, 8'h01, 1'b0, 1'b0);
		$display("test other opcode done");
	endtask : t_other

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	// inputs change on the falling edge, away from the sampling edge
	initial begin
		reset = 1'b1;
		instr = 16'h0000;
		instr_valid = 1'b0;
		status_flags = 8'h00;
		model_pc = fcb_pkg::PC_RESET;
		repeat (5) @(negedge clock);
		reset = 1'b0;
		t_negative();
		t_carry_clear();
		t_not_negative();
		t_bounds();
		t_other();
		final_report();
	end

	// about 60 clocks expected; a generous margin before calling it a hang
	initial begin
		#200000;
		miscompares++;
		final_report();
	end
endmodule : tb_top
